// *** src/maui_top.v ***
// Multichannel audio serial ports: pin sampling, clock masters, ratio detection
//
// Summary of operation
// - Slave ports take bit and word clocks in
// - Master ports drive bit and word clocks
// - Three DAC data lanes share receive clocks
// - ADC output has its own clock pair
// - ADC path may use ADC master clock
// - Four framings; far side matches the choice
// - Lengths 16/20/24/32, right justified lacks 32
// - Ratios 128 to 1152 times fs supported
// - Slave mode detects ratio without configuration
// - Master mode ratio comes from configuration
// - Any sample rate up to 192k accepted
// - Serial outputs change after bit clock fall
// - Serial inputs sampled on bit clock rise
// - Slave word clock captured on bit rise
// - Master word clock changes at bit fall
`timescale 1ns/1ns
`include "maui_regs.vh"

module maui_top (
  input  wire         ref_clk_in,
  input  wire         sys_rst_in,
  input  wire         clk_en_in,
  input  wire         main_master_clock_in,
  input  wire         adc_master_clock_in,
  input  wire         adc_clock_sel_in,
  input  wire         primary_rx_bit_clock_in,
  output wire         primary_rx_bit_clock_out,
  output wire         primary_rx_bit_clock_oe_out,
  input  wire         primary_rx_word_clock_in,
  output wire         primary_rx_word_clock_out,
  output wire         primary_rx_word_clock_oe_out,
  input  wire [2:0]   dac_serial_inputs_in,
  input  wire         primary_tx_bit_clock_in,
  output wire         primary_tx_bit_clock_out,
  output wire         primary_tx_bit_clock_oe_out,
  input  wire         primary_tx_word_clock_in,
  output wire         primary_tx_word_clock_out,
  output wire         primary_tx_word_clock_oe_out,
  output wire         primary_tx_serial_out,
  input  wire         secondary_bit_clock_in,
  output wire         secondary_bit_clock_out,
  output wire         secondary_bit_clock_oe_out,
  input  wire         secondary_word_clock_in,
  output wire         secondary_word_clock_out,
  output wire         secondary_word_clock_oe_out,
  input  wire         secondary_serial_in_in,
  output wire         secondary_serial_out_out,
  input  wire [2:0]   port_master_in,
  input  wire [5:0]   port_format_in,
  input  wire [5:0]   port_wlen_in,
  input  wire [8:0]   port_ratio_in,
  output wire [8:0]   port_ratio_det_out,
  output wire [2:0]   port_ratio_lock_out,
  output wire [191:0] dac_data_out,
  output wire         dac_valid_out,
  input  wire [31:0]  adc_left_in,
  input  wire [31:0]  adc_right_in,
  output wire         adc_taken_out,
  output wire [63:0]  sec_rx_data_out,
  output wire         sec_rx_valid_out,
  input  wire [31:0]  sec_tx_left_in,
  input  wire [31:0]  sec_tx_right_in,
  output wire         sec_tx_taken_out
);

  // Positions of the asynchronous inputs in the sampling bank
  localparam NASYNC   = 12;
  localparam IX_MCLK  = 0;
  localparam IX_AMCLK = 1;
  localparam IX_BCLK  = 2;
  localparam IX_LR    = 5;
  localparam IX_DIN   = 8;

  wire [NASYNC-1:0] raw_pins;  // Pins as they arrive
  wire [NASYNC-1:0] pin_lvl;   // Filtered levels
  wire [NASYNC-1:0] pin_rise;  // One-cycle rising events
  wire [2:0]        eff_bclk;  // Bit clock each engine follows
  wire [2:0]        eff_lr;    // Word clock each engine follows
  wire [2:0]        gen_bclk;  // Generated bit clocks
  wire [2:0]        gen_lr;    // Generated word clocks

  assign raw_pins = {secondary_serial_in_in, dac_serial_inputs_in,
                     secondary_word_clock_in, primary_tx_word_clock_in, primary_rx_word_clock_in,
                     secondary_bit_clock_in, primary_tx_bit_clock_in, primary_rx_bit_clock_in,
                     adc_master_clock_in, main_master_clock_in};

  // Frame length in master clocks for a ratio code
  function [10:0] frame_len(input [2:0] c);
    begin
      case (c)
        `MAUI_R128: frame_len = `MAUI_FRAME_128;
        `MAUI_R192: frame_len = `MAUI_FRAME_192;
        `MAUI_R256: frame_len = `MAUI_FRAME_256;
        `MAUI_R384: frame_len = `MAUI_FRAME_384;
        `MAUI_R512: frame_len = `MAUI_FRAME_512;
        `MAUI_R768: frame_len = `MAUI_FRAME_768;
        default:    frame_len = `MAUI_FRAME_1152;
      endcase
    end
  endfunction

  // Master clocks per bit clock; 64 bit clocks make one frame
  function [4:0] bit_div(input [2:0] c);
    begin
      case (c)
        `MAUI_R128: bit_div = `MAUI_DIV_128;
        `MAUI_R192: bit_div = `MAUI_DIV_192;
        `MAUI_R256: bit_div = `MAUI_DIV_256;
        `MAUI_R384: bit_div = `MAUI_DIV_384;
        `MAUI_R512: bit_div = `MAUI_DIV_512;
        `MAUI_R768: bit_div = `MAUI_DIV_768;
        default:    bit_div = `MAUI_DIV_1152;
      endcase
    end
  endfunction

  // Supported ratio within two master clocks of a measured frame, with a found flag
  function [3:0] match_ratio(input [10:0] cnt);
    integer c;
    reg [11:0] v;
    begin
      match_ratio = 4'h0;
      for (c = 0; c < 7; c = c + 1) begin
        v = {1'b0, frame_len(c[2:0])};
        if (({1'b0, cnt} + `MAUI_RATIO_TOL >= v) && ({1'b0, cnt} <= v + `MAUI_RATIO_TOL)) begin
          match_ratio = {1'b1, c[2:0]};
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Three-stage pin sampling; a level is taken once stages two and
  // three agree, which rejects a single-sample glitch
  genvar s;
  generate
    for (s = 0; s < NASYNC; s = s + 1) begin : g_pin
      reg s1;  // Metastability catcher, read only by s2
      reg s2;
      reg s3;
      reg lvl; // Accepted level
      reg lvl_d;
      always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          s1    <= 1'b0;
          s2    <= 1'b0;
          s3    <= 1'b0;
          lvl   <= 1'b0;
          lvl_d <= 1'b0;
        end else if (clk_en_in) begin
          s1    <= raw_pins[s];
          s2    <= s1;
          s3    <= s2;
          lvl_d <= lvl;
          if (s2 == s3) begin
            lvl <= s3;
          end
        end
      end
      assign pin_lvl[s]  = lvl;
      assign pin_rise[s] = lvl & ~lvl_d;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Per port: clock master, ratio detector and pin direction
  genvar p;
  generate
    for (p = 0; p < 3; p = p + 1) begin : g_port
      wire       master = port_master_in[p];
      wire [1:0] fmt    = port_format_in[2*p +: 2];
      // Transmit side may run from the dedicated ADC master clock
      wire       mrise  = (p == `MAUI_PORT_TX && adc_clock_sel_in) ?
                          pin_rise[IX_AMCLK] : pin_rise[IX_MCLK];
      wire [4:0] div    = bit_div(port_ratio_in[3*p +: 3]);
      wire [4:0] half   = {1'b0, div[4:1]};
      reg  [4:0] mcnt;   // Master clocks within the bit period
      reg  [5:0] gbit;   // Bit index within the frame
      reg        gbclk;  // Driven bit clock
      reg        glr;    // Driven word clock
      reg  [10:0] rcnt;  // Master clocks since last word clock rise
      reg        lr_d;   // Followed word clock one cycle ago
      reg  [2:0] det;    // Detected ratio code
      reg        lock;   // Detected ratio is a supported one
      wire [4:0] nxt_m  = (mcnt >= div - 5'h01) ? 5'h00 : (mcnt + 5'h01);
      wire [5:0] nxt_b  = gbit + 6'h01;
      wire [3:0] hit    = match_ratio(rcnt);

      // Bit clock high at count zero, low at half; the word clock
      // moves with the falling edge so it is settled at the rise
      always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          mcnt  <= 5'h00;
          gbit  <= 6'h00;
          gbclk <= 1'b0;
          glr   <= 1'b0;
        end else if (clk_en_in) begin
          if (!master) begin
            mcnt  <= 5'h00;
            gbit  <= 6'h00;
            gbclk <= 1'b0;
            glr   <= 1'b0;
          end else if (mrise) begin
            mcnt <= nxt_m;
            if (nxt_m == 5'h00) begin
              gbclk <= 1'b1;
            end else if (nxt_m == half && gbclk) begin // No fall without a rise, after reset or a ratio change
              gbclk <= 1'b0;
              gbit  <= nxt_b;
              case (fmt)
                `MAUI_FMT_I2S: glr <= nxt_b[5];
                `MAUI_FMT_DSP: glr <= (nxt_b == 6'h00);
                default:       glr <= ~nxt_b[5];
              endcase
            end
          end
        end
      end

      // Frame length in master clocks; counts at any frame rate, so
      // low sample rates only need a master clock of matching ratio
      always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          rcnt <= 11'h000;
          lr_d <= 1'b0;
          det  <= `MAUI_R256;
          lock <= 1'b0;
        end else if (clk_en_in) begin
          lr_d <= eff_lr[p];
          if (eff_lr[p] & ~lr_d) begin
            rcnt <= mrise ? 11'h001 : 11'h000;
            lock <= hit[3];
            if (hit[3]) begin
              det <= hit[2:0];
            end
          end else if (mrise && rcnt != `MAUI_RATIO_MAX) begin
            rcnt <= rcnt + 11'h001;
          end
        end
      end

      assign gen_bclk[p] = gbclk;
      assign gen_lr[p]   = glr;
      // Slave follows the pins, master follows its own clocks
      assign eff_bclk[p] = master ? gbclk : pin_lvl[IX_BCLK + p];
      assign eff_lr[p]   = master ? glr : pin_lvl[IX_LR + p];
      assign port_ratio_det_out[3*p +: 3] = det;
      assign port_ratio_lock_out[p]       = lock;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: enables follow the master selection
  assign primary_rx_bit_clock_out     = gen_bclk[`MAUI_PORT_RX];
  assign primary_rx_bit_clock_oe_out  = port_master_in[`MAUI_PORT_RX];
  assign primary_rx_word_clock_out    = gen_lr[`MAUI_PORT_RX];
  assign primary_rx_word_clock_oe_out = port_master_in[`MAUI_PORT_RX];
  assign primary_tx_bit_clock_out     = gen_bclk[`MAUI_PORT_TX];
  assign primary_tx_bit_clock_oe_out  = port_master_in[`MAUI_PORT_TX];
  assign primary_tx_word_clock_out    = gen_lr[`MAUI_PORT_TX];
  assign primary_tx_word_clock_oe_out = port_master_in[`MAUI_PORT_TX];
  assign secondary_bit_clock_out      = gen_bclk[`MAUI_PORT_SEC];
  assign secondary_bit_clock_oe_out   = port_master_in[`MAUI_PORT_SEC];
  assign secondary_word_clock_out     = gen_lr[`MAUI_PORT_SEC];
  assign secondary_word_clock_oe_out  = port_master_in[`MAUI_PORT_SEC];

  ////////////////////////////////////////////////////////////////////////
  // Receive side: three DAC lanes on one shared clock pair
  maui_frame #(.NIN(3)) u_rx (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_en_in    (clk_en_in),
    .bclk_in      (eff_bclk[`MAUI_PORT_RX]),
    .lr_in        (eff_lr[`MAUI_PORT_RX]),
    .din_in       (pin_lvl[IX_DIN +: 3]),
    .format_in    (port_format_in[1:0]),
    .wlen_in      (port_wlen_in[1:0]),
    .tx_left_in   (32'h0),
    .tx_right_in  (32'h0),
    .rx_data_out  (dac_data_out),
    .rx_valid_out (dac_valid_out),
    .tx_taken_out (),
    .dout_out     ()
  );

  // Transmit side: ADC words on a clock pair of their own
  maui_frame #(.NIN(1)) u_tx (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_en_in    (clk_en_in),
    .bclk_in      (eff_bclk[`MAUI_PORT_TX]),
    .lr_in        (eff_lr[`MAUI_PORT_TX]),
    .din_in       (1'b0),
    .format_in    (port_format_in[3:2]),
    .wlen_in      (port_wlen_in[3:2]),
    .tx_left_in   (adc_left_in),
    .tx_right_in  (adc_right_in),
    .rx_data_out  (),
    .rx_valid_out (),
    .tx_taken_out (adc_taken_out),
    .dout_out     (primary_tx_serial_out)
  );

  // Secondary port: one lane each way
  maui_frame #(.NIN(1)) u_sec (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .clk_en_in    (clk_en_in),
    .bclk_in      (eff_bclk[`MAUI_PORT_SEC]),
    .lr_in        (eff_lr[`MAUI_PORT_SEC]),
    .din_in       (pin_lvl[IX_DIN + 3]),
    .format_in    (port_format_in[5:4]),
    .wlen_in      (port_wlen_in[5:4]),
    .tx_left_in   (sec_tx_left_in),
    .tx_right_in  (sec_tx_right_in),
    .rx_data_out  (sec_rx_data_out),
    .rx_valid_out (sec_rx_valid_out),
    .tx_taken_out (sec_tx_taken_out),
    .dout_out     (secondary_serial_out_out)
  );

endmodule

// *** src/maui_regs.vh ***
// Constant set shared by the multichannel audio serial port design files
`ifndef MAUI_REGS_VH
`define MAUI_REGS_VH

// Framing formats, one 2-bit field per port
`define MAUI_FMT_RJ      2'h0
`define MAUI_FMT_LJ      2'h1
`define MAUI_FMT_I2S     2'h2
`define MAUI_FMT_DSP     2'h3

// Word length codes and their bit counts
`define MAUI_WL_16       2'h0
`define MAUI_WL_20       2'h1
`define MAUI_WL_24       2'h2
`define MAUI_WL_32       2'h3
`define MAUI_BITS_16     8'h10
`define MAUI_BITS_20     8'h14
`define MAUI_BITS_24     8'h18
`define MAUI_BITS_32     8'h20

// Master clock to sample rate ratio codes
`define MAUI_R128        3'h0
`define MAUI_R192        3'h1
`define MAUI_R256        3'h2
`define MAUI_R384        3'h3
`define MAUI_R512        3'h4
`define MAUI_R768        3'h5
`define MAUI_R1152       3'h6

// Master clocks per sample frame for each ratio
`define MAUI_FRAME_128   11'h080
`define MAUI_FRAME_192   11'h0c0
`define MAUI_FRAME_256   11'h100
`define MAUI_FRAME_384   11'h180
`define MAUI_FRAME_512   11'h200
`define MAUI_FRAME_768   11'h300
`define MAUI_FRAME_1152  11'h480

// Master clocks per generated bit clock (frame of 64 bit clocks)
`define MAUI_DIV_128     5'h02
`define MAUI_DIV_192     5'h03
`define MAUI_DIV_256     5'h04
`define MAUI_DIV_384     5'h06
`define MAUI_DIV_512     5'h08
`define MAUI_DIV_768     5'h0c
`define MAUI_DIV_1152    5'h12

// Ratio detection tolerance in master clocks, counter ceiling
`define MAUI_RATIO_TOL   12'h002
`define MAUI_RATIO_MAX   11'h7ff

// Slot length assumed before the first measured half frame
`define MAUI_SLOT_RESET  8'h20

// Port indices
`define MAUI_PORT_RX     0
`define MAUI_PORT_TX     1
`define MAUI_PORT_SEC    2

`endif

// *** src/maui_frame.v ***
// Framing engine for one audio port: serial capture and serial transmit
`timescale 1ns/1ns
`include "maui_regs.vh"

module maui_frame #(
  parameter NIN = 1
) (
  input  wire             ref_clk_in,
  input  wire             sys_rst_in,
  input  wire             clk_en_in,
  input  wire             bclk_in,
  input  wire             lr_in,
  input  wire [NIN-1:0]   din_in,
  input  wire [1:0]       format_in,
  input  wire [1:0]       wlen_in,
  input  wire [31:0]      tx_left_in,
  input  wire [31:0]      tx_right_in,
  output wire [NIN*64-1:0] rx_data_out,
  output reg              rx_valid_out,
  output reg              tx_taken_out,
  output reg              dout_out
);

  reg        bclk_d;   // Bit clock level one cycle ago
  reg        lr_prev;  // Word clock seen at the last rising edge
  reg  [7:0] pos;      // Bit position since the last boundary
  reg        chan;     // Current channel, 1 is right
  reg  [7:0] slot;     // Measured bits per half frame
  reg  [1:0] fall_q;   // Falling edge delayed so word clock settles
  reg  [63:0] tx_hold; // Stereo word being sent, left in upper half

  // Bit count of the selected length; 32 is not offered right justified
  function [7:0] word_len(input [1:0] f, input [1:0] w);
    begin
      case (w)
        `MAUI_WL_16: word_len = `MAUI_BITS_16;
        `MAUI_WL_20: word_len = `MAUI_BITS_20;
        `MAUI_WL_24: word_len = `MAUI_BITS_24;
        default:     word_len = (f == `MAUI_FMT_RJ) ? `MAUI_BITS_24 : `MAUI_BITS_32;
      endcase
    end
  endfunction

  // First data bit position of a channel for each format
  function [7:0] start_of(input [1:0] f, input ch, input [7:0] sl, input [7:0] wl);
    begin
      case (f)
        `MAUI_FMT_LJ:  start_of = 8'h00;
        `MAUI_FMT_I2S: start_of = 8'h01;
        `MAUI_FMT_DSP: start_of = ch ? (wl + 8'h01) : 8'h01;
        default:       start_of = (sl > wl) ? (sl - wl) : 8'h00;
      endcase
    end
  endfunction

  wire       rise    = bclk_in & ~bclk_d;
  wire       fall    = ~bclk_in & bclk_d;
  wire       is_dsp  = (format_in == `MAUI_FMT_DSP);
  // DSP marks frames by a word clock pulse, others by any change
  wire       bound   = is_dsp ? (lr_in & ~lr_prev) : (lr_in ^ lr_prev);
  wire       lr_chan = (format_in == `MAUI_FMT_I2S) ? lr_in : ~lr_in;
  wire [7:0] wl      = word_len(format_in, wlen_in);
  wire [7:0] pos_inc = (pos == 8'hff) ? pos : (pos + 8'h01);
  // Position of the bit at the coming (or current) rising edge
  wire [7:0] cur_pos = bound ? 8'h00 : pos_inc;
  wire       cur_ch  = is_dsp ? (cur_pos > wl) : (bound ? lr_chan : chan);
  wire [7:0] cur_st  = start_of(format_in, cur_ch, slot, wl);
  wire [7:0] cur_k   = cur_pos - cur_st;
  wire       in_word = (cur_pos >= cur_st) && (cur_k < wl);
  wire       last_bit = in_word && (cur_k == (wl - 8'h01));
  // Transmit word source; a fresh pair is taken at the left start
  wire       load    = fall_q[1] & bound & (is_dsp | ~lr_chan);
  wire [63:0] wsrc   = load ? {tx_left_in, tx_right_in} : tx_hold;
  wire [31:0] wsel   = cur_ch ? wsrc[31:0] : wsrc[63:32];
  wire [7:0] bit_idx = wl - 8'h01 - cur_k;

  ////////////////////////////////////////////////////////////////////////
  // Frame tracking on rising bit clock edges
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bclk_d  <= 1'b0;
      lr_prev <= 1'b0;
      pos     <= 8'h00;
      chan    <= 1'b0;
      slot    <= `MAUI_SLOT_RESET;
      fall_q  <= 2'h0;
    end else if (clk_en_in) begin
      bclk_d <= bclk_in;
      fall_q <= {fall_q[0], fall};
      if (rise) begin
        lr_prev <= lr_in;
        pos     <= cur_pos;
        chan    <= cur_ch;
        // Half frame length feeds right justified alignment
        if (bound && !is_dsp) begin
          slot <= pos_inc;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial output and word hand-off; a short delay after the falling
  // edge lets a word clock change from the far master be seen first
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      tx_hold      <= 64'h0;
      dout_out     <= 1'b0;
      tx_taken_out <= 1'b0;
    end else if (clk_en_in) begin
      tx_taken_out <= load;
      if (load) begin
        tx_hold <= wsrc;
      end
      if (fall_q[1]) begin
        dout_out <= in_word ? wsel[bit_idx[4:0]] : 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame complete once the last right channel bit is in
  always @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rx_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      rx_valid_out <= rise & last_bit & cur_ch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One capture shifter per data lane, words right aligned
  genvar l;
  generate
    for (l = 0; l < NIN; l = l + 1) begin : g_lane
      reg [31:0] sh;     // Bits of the word in progress
      reg [31:0] left_w; // Last complete left word
      reg [31:0] right_w; // Last complete right word
      always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          sh      <= 32'h0;
          left_w  <= 32'h0;
          right_w <= 32'h0;
        end else if (clk_en_in && rise && in_word) begin
          sh <= (cur_k == 8'h00) ? {31'h0, din_in[l]} : {sh[30:0], din_in[l]};
          if (last_bit && cur_ch) begin
            right_w <= {sh[30:0], din_in[l]};
          end else if (last_bit) begin
            left_w <= {sh[30:0], din_in[l]};
          end
        end
      end
      assign rx_data_out[l*64 +: 64] = {left_w, right_w};
    end
  endgenerate

endmodule

// *** test/maui_props.sv ***
// Concurrent checks on the audio port pins and strobes
`timescale 1ns/1ns
module maui_chk (
  input wire       ref_clk_in,
  input wire       sys_rst_in,
  input wire       clk_en_in,
  input wire [2:0] port_master_in,
  input wire       primary_rx_bit_clock_oe_out,
  input wire       primary_tx_bit_clock_oe_out,
  input wire       primary_tx_bit_clock_out,
  input wire       primary_tx_word_clock_out,
  input wire       secondary_bit_clock_out,
  input wire       secondary_word_clock_out,
  input wire       primary_tx_serial_out,
  input wire       dac_valid_out,
  input wire       adc_taken_out,
  input wire [8:0] port_ratio_det_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  // Strobe high for exactly one cycle
  sequence s_one(s);
    s ##1 !s;
  endsequence
  chk_rx_pin_dir: assert property (primary_rx_bit_clock_oe_out == port_master_in[0])
    else $error("rx bit clock direction wrong");
  chk_tx_pin_dir: assert property (primary_tx_bit_clock_oe_out == port_master_in[1])
    else $error("tx bit clock direction wrong");
  // Word clock may move only with a bit clock fall
  chk_tx_word_edge: assert property (port_master_in[1] && $changed(primary_tx_word_clock_out)
    |-> $fell(primary_tx_bit_clock_out)) else $error("tx word clock off the fall");
  chk_sec_word_edge: assert property (port_master_in[2] && $changed(secondary_word_clock_out)
    |-> $fell(secondary_bit_clock_out)) else $error("sec word clock off the fall");
  // Data must not move while the bit clock is high
  chk_tx_data_edge: assert property (port_master_in[1] && $changed(primary_tx_serial_out)
    |-> !primary_tx_bit_clock_out) else $error("tx data moved in high phase");
  chk_dac_valid_pulse: assert property (dac_valid_out |-> s_one(dac_valid_out))
    else $error("dac valid longer than one cycle");
  chk_adc_taken_pulse: assert property (adc_taken_out |-> s_one(adc_taken_out))
    else $error("adc taken longer than one cycle");
  // Reset itself is the cause here, so only the enable gates it
  chk_det_reset_val: assert property (@(posedge ref_clk_in) disable iff (!clk_en_in)
    sys_rst_in |=> port_ratio_det_out == 9'h092) else $error("detected ratio not 256 after reset");
endmodule
bind maui_top maui_chk maui_chk_i (.ref_clk_in, .sys_rst_in, .clk_en_in, .port_master_in,
  .primary_rx_bit_clock_oe_out, .primary_tx_bit_clock_oe_out, .primary_tx_bit_clock_out,
  .primary_tx_word_clock_out, .secondary_bit_clock_out, .secondary_word_clock_out,
  .primary_tx_serial_out, .dac_valid_out, .adc_taken_out, .port_ratio_det_out);

// *** test/maui_host.sv ***
// Host serial audio source, clock master toward the receive port
`timescale 1ns/1ns
module maui_host (
  output logic       bclk_out,
  output logic       wclk_out,
  output logic [2:0] din_out
);
  // Bit clock rests high between frames
  initial begin
    bclk_out = 1'b1;
    wclk_out = 1'b0;
    din_out  = 3'h0;
  end
  ////////////////////////////////////////
  // One frame of 2*h bits; lane l sends the words plus l
  task send(input logic [1:0] fmt, input int h, input logic [15:0] lw, input logic [15:0] rw);
    int          j, l, off, rs;
    logic [15:0] a, b;
    for (j = 0; j < 2 * h; j++) begin
      off = (fmt == 2'h0) ? h - 16 : (fmt == 2'h1) ? 0 : 1;
      rs  = (fmt == 2'h3) ? 17 : h + off;
      bclk_out = 1'b0;
      // Word clock moves at the fall, settled long before the rise
      wclk_out = (fmt == 2'h3) ? (j == 0) : (fmt == 2'h2) ? (j >= h) : (j < h);
      for (l = 0; l < 3; l++) begin
        a = lw + 16'(l);
        b = rw + 16'(l);
        // MSB first; idle line flips so a stale bit never passes
        if (j >= off && j < off + 16)
          din_out[l] = a[off + 15 - j];
        else if (j >= rs && j < rs + 16)
          din_out[l] = b[rs + 15 - j];
        else
          din_out[l] = ~din_out[l];
      end
      #200;
      bclk_out = 1'b1;
      #200;
    end
  endtask
endmodule

// *** test/tb_top.sv ***
// Bench: host feeds the receive port, transmit and secondary ports run as masters
`timescale 1ns/1ns
module tb_top;
  logic         ref_clk_in = 1'b0;
  logic         sys_rst_in = 1'b1;
  logic         mclk       = 1'b0;  // Main master clock, 400 ns
  logic         amclk      = 1'b0;  // ADC master clock, 800 ns
  logic         sel        = 1'b0;
  logic [5:0]   fmt        = 6'h15;
  logic [8:0]   ratio      = 9'h052;
  logic [31:0]  sl         = 32'hc471_5a3c;
  logic [31:0]  sr         = 32'h3be8_c3a5;
  wire          hb, hw, rxb, rxw, txb, txw, sb, sw, sdo;
  wire          rxb_o, rxb_e, rxw_o, rxw_e, txb_o, txb_e, txw_o, txw_e, sb_o, sb_e, sw_o, sw_e;
  wire  [2:0]   hd, lock;
  wire  [8:0]   det;
  wire  [63:0]  srx;
  wire  [191:0] dac;
  int           n_mismatch  = 0;
  int           checks_done = 0;
  int           cycles      = 0;
  int           cyc, nb, k;
  // Pin level: design while enabled, else the far side
  assign rxb = rxb_e ? rxb_o : hb;
  assign rxw = rxw_e ? rxw_o : hw;
  assign txb = txb_e ? txb_o : 1'b0;
  assign txw = txw_e ? txw_o : 1'b0;
  assign sb  = sb_e ? sb_o : 1'b0;
  assign sw  = sw_e ? sw_o : 1'b0;
  always #25 ref_clk_in = ~ref_clk_in;
  always #200 mclk = ~mclk;
  always #400 amclk = ~amclk;
  // Hang guard; the run needs about 55k cycles
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 70000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  maui_host maui_host_i (.bclk_out(hb), .wclk_out(hw), .din_out(hd));
  // Secondary data out loops back into its own input
  maui_top maui_top_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .main_master_clock_in(mclk), .adc_master_clock_in(amclk), .adc_clock_sel_in(sel),
    .primary_rx_bit_clock_in(rxb), .primary_rx_bit_clock_out(rxb_o), .primary_rx_bit_clock_oe_out(rxb_e),
    .primary_rx_word_clock_in(rxw), .primary_rx_word_clock_out(rxw_o), .primary_rx_word_clock_oe_out(rxw_e),
    .dac_serial_inputs_in(hd), .primary_tx_serial_out(),
    .primary_tx_bit_clock_in(txb), .primary_tx_bit_clock_out(txb_o), .primary_tx_bit_clock_oe_out(txb_e),
    .primary_tx_word_clock_in(txw), .primary_tx_word_clock_out(txw_o), .primary_tx_word_clock_oe_out(txw_e),
    .secondary_bit_clock_in(sb), .secondary_bit_clock_out(sb_o), .secondary_bit_clock_oe_out(sb_e),
    .secondary_word_clock_in(sw), .secondary_word_clock_out(sw_o), .secondary_word_clock_oe_out(sw_e),
    .secondary_serial_in_in(sdo), .secondary_serial_out_out(sdo), .port_master_in(3'h6),
    .port_format_in(fmt), .port_wlen_in(6'h20), .port_ratio_in(ratio), .port_ratio_det_out(det),
    .port_ratio_lock_out(lock), .dac_data_out(dac), .dac_valid_out(), .adc_left_in(sl), .adc_right_in(sr),
    .adc_taken_out(), .sec_rx_data_out(srx), .sec_rx_valid_out(), .sec_tx_left_in(sl), .sec_tx_right_in(sr),
    .sec_tx_taken_out());
  ////////////////////////////////////////
  task chk(input logic [191:0] got, input logic [191:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Three lanes of right-aligned 16-bit words
  function automatic logic [191:0] lanes(input logic [15:0] lw, input logic [15:0] rw);
    logic [191:0] v;
    v = '0;
    for (int l = 0; l < 3; l++)
      v[l * 64 +: 64] = {16'h0, lw + 16'(l), 16'h0, rw + 16'(l)};
    return v;
  endfunction
  // Frame length and bit clock count between transmit word clock rises
  task meas(output int c, output int n);
    int   st;
    logic pw, pb;
    c = 0;
    n = 0;
    st = 0;
    pw = 1'b1;
    pb = 1'b1;
    while (st < 2 && c < 9000) begin
      @(negedge ref_clk_in);
      if (st == 1)
        c++;
      if (st == 1 && txb && !pb)
        n++;
      if (txw && !pw)
        st++;
      pw = txw;
      pb = txb;
    end
  endtask
  task wrap_up;
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    chk(det, 9'h092);
    // Every framing at 128 fs; third frame is judged
    for (k = 0; k < 4; k++) begin
      fmt[1:0] = k[1:0];
      repeat (3) maui_host_i.send(k[1:0], 64, 16'h9a5c + 16'(k), 16'h36e1 - 16'(k));
      repeat (20) @(negedge ref_clk_in);
      chk(dac, lanes(16'h9a5c + 16'(k), 16'h36e1 - 16'(k)));
      chk(det[2:0], 3'h0);
      chk(lock[0], 1'b1);
    end
    // Longer frame on the same master clock reads as 192 fs
    fmt[1:0] = 2'h1;
    repeat (3) maui_host_i.send(2'h1, 96, 16'h0f0f, 16'hf0f0);
    repeat (20) @(negedge ref_clk_in);
    chk(det[2:0], 3'h1);
    chk(dac, lanes(16'h0f0f, 16'hf0f0));
    // Transmit master: ratio and clock source table
    for (k = 0; k < 3; k++) begin
      sel = (k == 1);
      ratio[5:3] = (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : 3'h4;
      meas(cyc, nb);
      meas(cyc, nb);
      chk(nb, 64);
      chk((cyc + (sel ? 8 : 4)) / (sel ? 16 : 8), (k == 0) ? 192 : (k == 1) ? 256 : 512);
    end
    chk(srx, {8'h0, sl[23:0], 8'h0, sr[23:0]});
    wrap_up();
  end
endmodule
